// >>> pkg/pcs_pkg.sv
`default_nettype none
package pcs_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses of configuration words)
    // ------------------------------------------------------------
    localparam logic [7:0] PCS_OFF_ID  = 8'h00;
    localparam logic [7:0] PCS_OFF_CSR = 8'h04;

    // ------------------------------------------------------------
    // command/status field positions
    // ------------------------------------------------------------
    localparam int PCS_BIT_DPE     = 31;
    localparam int PCS_BIT_SSERR   = 30;
    localparam int PCS_BIT_RMA     = 29;
    localparam int PCS_BIT_RTA     = 28;
    localparam int PCS_BIT_STA     = 27;
    localparam int PCS_BIT_DSEL_HI = 26;
    localparam int PCS_BIT_DSEL_LO = 25;
    localparam int PCS_BIT_MDP     = 24;
    localparam int PCS_BIT_TBTB    = 23;
    localparam int PCS_BIT_MBTB    = 9;
    localparam int PCS_BIT_SERREN  = 8;
    localparam int PCS_BIT_WAIT    = 7;
    localparam int PCS_BIT_PARITY_ERROR_RESPONSE  = 6;

    // ------------------------------------------------------------
    // fixed and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  PCS_DSEL_MEDIUM = 2'h1;
    localparam logic        PCS_FLAG_RST    = 1'h0;
    localparam logic        PCS_EN_RST      = 1'h0;
    localparam logic        PCS_TBTB_VAL    = 1'h0;
    localparam logic        PCS_MBTB_VAL    = 1'h0;
    localparam logic [31:0] PCS_RD_NONE     = 32'h0000_0000;
endpackage : pcs_pkg
`default_nettype wire

// >>> rtl/pcs_cfg_regs.sv
`default_nettype none
module pcs_cfg_regs
    import pcs_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h5678  // arbitrary value
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    input  wire logic        mst_data_perr,
    input  wire logic        mst_perr_seen,
    input  wire logic        mst_master_abort,
    input  wire logic        mst_target_abort,
    input  wire logic        tgt_addr_perr,
    input  wire logic        tgt_data_perr,
    input  wire logic        tgt_target_abort,
    output logic             serr_req,
    output logic             addr_perr_refuse,
    output logic             perr_allow
);
    // ------------------------------------------------------------
    // command bits
    // ------------------------------------------------------------
    logic system_error_enable_ff;
    logic parity_error_response_ff;
    logic wr_csr_lo;
    logic wr_csr_hi;
    logic wr_csr;

    assign wr_csr    = cfg_wr && (cfg_addr == PCS_OFF_CSR);
    assign wr_csr_lo = wr_csr && cfg_be[0];
    assign wr_csr_hi = wr_csr && cfg_be[1];

    // parity response lives in byte 0, serr enable in byte 1
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            parity_error_response_ff  <= PCS_EN_RST;
            system_error_enable_ff <= PCS_EN_RST;
        end else begin
            if (wr_csr_lo) begin
                parity_error_response_ff <= cfg_wdata[PCS_BIT_PARITY_ERROR_RESPONSE];
            end
            if (wr_csr_hi) begin
                system_error_enable_ff <= cfg_wdata[PCS_BIT_SERREN];
            end
        end
    end

    // ------------------------------------------------------------
    // error reporting outputs
    // ------------------------------------------------------------
    // serr needs both enables, so an address parity error is also refused
    assign addr_perr_refuse = parity_error_response_ff && system_error_enable_ff;
    assign serr_req         = tgt_addr_perr && parity_error_response_ff && system_error_enable_ff;
    assign perr_allow       = parity_error_response_ff;

    // ------------------------------------------------------------
    // sticky status flags, write one to clear, set wins over clear
    // ------------------------------------------------------------
    logic       clr_en;
    logic [7:0] flag_set;
    logic [7:0] flags_ff;   // [7]=dpe .. [0]=mdp, dsel slots unused

    assign clr_en = wr_csr && cfg_be[3];

    always_comb begin
        flag_set    = 8'h00;
        flag_set[7] = mst_data_perr || tgt_addr_perr || tgt_data_perr;
        flag_set[6] = serr_req;
        flag_set[5] = mst_master_abort;
        flag_set[4] = mst_target_abort;
        flag_set[3] = tgt_target_abort;
        flag_set[0] = parity_error_response_ff && mst_perr_seen;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            if (gi == 1 || gi == 2) begin : g_none
                assign flags_ff[gi] = 1'h0;  // device select slot, fixed
            end else begin : g_sticky
                logic bit_ff;
                always_ff @(posedge clk_sys or negedge rstn) begin
                    if (!rstn) begin
                        bit_ff <= PCS_FLAG_RST;
                    end else if (flag_set[gi]) begin
                        bit_ff <= 1'h1;
                    end else if (clr_en && cfg_wdata[PCS_BIT_MDP+gi]) begin
                        bit_ff <= 1'h0;
                    end
                end
                assign flags_ff[gi] = bit_ff;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] csr_word;
    logic [31:0] nxt_rdata;

    always_comb begin
        csr_word = 32'h0000_0000;
        csr_word[PCS_BIT_DPE]   = flags_ff[7];
        csr_word[PCS_BIT_SSERR] = flags_ff[6];
        csr_word[PCS_BIT_RMA]   = flags_ff[5];
        csr_word[PCS_BIT_RTA]   = flags_ff[4];
        csr_word[PCS_BIT_STA]   = flags_ff[3];
        csr_word[PCS_BIT_DSEL_HI:PCS_BIT_DSEL_LO] = PCS_DSEL_MEDIUM;
        csr_word[PCS_BIT_MDP]   = flags_ff[0];
        csr_word[PCS_BIT_TBTB]  = PCS_TBTB_VAL;
        csr_word[PCS_BIT_MBTB]  = PCS_MBTB_VAL;
        csr_word[PCS_BIT_SERREN] = system_error_enable_ff;
        csr_word[PCS_BIT_PARITY_ERROR_RESPONSE] = parity_error_response_ff;
        if (cfg_addr == PCS_OFF_ID) begin
            nxt_rdata = {DEVICE_ID, VENDOR_ID};
        end else if (cfg_addr == PCS_OFF_CSR) begin
            nxt_rdata = csr_word;
        end else begin
            nxt_rdata = PCS_RD_NONE;
        end
    end

    // data registered one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata <= PCS_RD_NONE;
        end else if (cfg_rd) begin
            cfg_rdata <= nxt_rdata;
        end
    end
endmodule : pcs_cfg_regs
`default_nettype wire

// >>> tb/pcs_cfg_regs_assertions.sv
`default_nettype none
module pcs_cfg_regs_assertions #(
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h5678  // arbitrary value
) (
    input wire logic clk_sys, rstn, cfg_rd, cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata, cfg_rdata,
    input wire logic mst_data_perr, mst_perr_seen, mst_master_abort, mst_target_abort,
    input wire logic tgt_addr_perr, tgt_data_perr, tgt_target_abort, serr_req, addr_perr_refuse, perr_allow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // csr read; its data lands one edge later
    sequence rd_csr; cfg_rd && cfg_addr == 8'h04; endsequence
    a_serr_gated: assert property (serr_req |-> addr_perr_refuse)
        else $error("serr request without enables");
    a_serr_cause: assert property (tgt_addr_perr && addr_perr_refuse |-> serr_req)
        else $error("address parity error not signalled");
    a_refuse_both: assert property (addr_perr_refuse |-> perr_allow)
        else $error("refuse without parity response");
    a_id_value: assert property (cfg_rd && cfg_addr == 8'h00 |=> cfg_rdata == {DEVICE_ID, VENDOR_ID})
        else $error("id word wrong");
    a_fixed_bits: assert property (rd_csr |=> cfg_rdata[26:25] == 2'h1 && !cfg_rdata[23] && !cfg_rdata[9])
        else $error("fixed csr bits wrong");
    a_dpe_set: assert property ((mst_data_perr || tgt_addr_perr || tgt_data_perr) ##1 rd_csr |=> cfg_rdata[31])
        else $error("parity flag not set");
    a_rma_set: assert property (mst_master_abort ##1 rd_csr |=> cfg_rdata[29])
        else $error("master abort flag not set");
    a_rta_set: assert property (mst_target_abort ##1 rd_csr |=> cfg_rdata[28])
        else $error("received abort flag not set");
    a_sta_set: assert property (tgt_target_abort ##1 rd_csr |=> cfg_rdata[27])
        else $error("signalled abort flag not set");
    a_mdp_set: assert property (mst_perr_seen && perr_allow ##1 rd_csr |=> cfg_rdata[24])
        else $error("master parity flag not set");
    a_resp_write: assert property (cfg_wr && cfg_addr == 8'h04 && cfg_be[0] |=> perr_allow == $past(cfg_wdata[6]))
        else $error("parity response not written");
endmodule : pcs_cfg_regs_assertions
`default_nettype wire

// >>> tb/pcs_cfg_regs_test.sv
`default_nettype none
module pcs_cfg_regs_test;
    import pcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rstn = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0, serr_req, addr_perr_refuse, perr_allow;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
    logic [6:0] ev;
    int num_errors = 0, compares = 0;
    initial forever #4 clk_sys = ~clk_sys;
    pcs_host_model host (.clk_sys(clk_sys), .ev(ev));
    pcs_cfg_regs dut (.clk_sys(clk_sys), .rstn(rstn), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .mst_data_perr(ev[6]), .mst_perr_seen(ev[5]),
        .mst_master_abort(ev[4]), .mst_target_abort(ev[3]), .tgt_addr_perr(ev[2]), .tgt_data_perr(ev[1]),
        .tgt_target_abort(ev[0]), .serr_req(serr_req), .addr_perr_refuse(addr_perr_refuse), .perr_allow(perr_allow));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(negedge clk_sys) {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, b, d};
        @(negedge clk_sys) cfg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk_sys) {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge clk_sys) cfg_rd = 1'b0;
        chk(cfg_rdata, exp);
    endtask : rd
    task automatic final_report;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // watchdog: nothing here may take this long
    initial begin #200000 num_errors++; final_report(); end
    initial begin
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        wr(8'h00, 4'hf, 32'hffff_ffff);
        rd(8'h00, 32'h5678_1234);
        rd(8'h04, 32'h0200_0000);
        rd(8'h08, 32'h0000_0000);
        $display("test id and reset done");
        wr(8'h04, 4'h3, 32'h0000_03c0);
        rd(8'h04, 32'h0200_0140);
        chk({30'h0, addr_perr_refuse, perr_allow}, 32'h3);
        host.fire(7'h7f);
        rd(8'h04, 32'hfb00_0140);
        wr(8'h04, 4'h8, 32'hf900_0000);
        rd(8'h04, 32'h0200_0140);
        $display("test flags done");
        wr(8'h04, 4'h3, 32'h0000_0040);
        chk({30'h0, addr_perr_refuse, perr_allow}, 32'h1);
        host.fire(7'h7f);
        rd(8'h04, 32'hbb00_0040);
        wr(8'h04, 4'hb, 32'hf900_0000);
        host.fire(7'h7f);
        rd(8'h04, 32'hba00_0000);
        $display("test enables done");
        final_report();
    end
endmodule : pcs_cfg_regs_test
bind pcs_cfg_regs pcs_cfg_regs_assertions #(.VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID)) u_chk (.*);
`default_nettype wire

// >>> tb/pcs_host_model.sv
`default_nettype none
module pcs_host_model (
    input  wire logic       clk_sys,
    output logic      [6:0] ev
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ev = 7'h00;
    // one-cycle event pulses, launched off the falling edge
    task automatic fire(input logic [6:0] m);
        @(negedge clk_sys) ev = m;
        @(negedge clk_sys) ev = 7'h00;
    endtask : fire
endmodule : pcs_host_model
`default_nettype wire
